// *** hdl/cardbus_card_end.sv ***
`timescale 1ns/1ps
module cardbus_card_end
   import cardbus_clk_pkg::*;
#(
   parameter int W = BUS_W,
   parameter int PULSE_CYC = CARD_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic need_clk,
   input wire logic [W-1:0] tx_data,
   output logic in_reset,
   output logic run_req_active,
   output logic [W-1:0] rx_data,
   cardbus_link_if.card link
);
   logic cclk_s1_reg;
   logic cclk_s2_reg;
   logic cclk_s3_reg;
   logic crst_s1_reg;
   logic crst_s2_reg;
   logic run_s1_reg;
   logic run_s2_reg;
   logic [W-1:0] bus_s1_reg;
   logic [W-1:0] bus_s2_reg;
   logic [$clog2(PULSE_CYC+1)-1:0] pulse_reg;
   logic run_oe_n_reg;
   logic bus_oe_n_reg;
   logic [W-1:0] bus_o_reg;
   logic resetting;
   logic cclk_rise;

   // Every socket input is foreign to this clock, so each is synchronised.
   always_ff @(posedge sys_clk) begin
      cclk_s1_reg <= link.cclk;
      cclk_s2_reg <= cclk_s1_reg;
      cclk_s3_reg <= cclk_s2_reg;
      crst_s1_reg <= link.crst_n;
      crst_s2_reg <= crst_s1_reg;
      run_s1_reg <= link.clkrun_n;
      run_s2_reg <= run_s1_reg;
      bus_s1_reg <= link.bus;
      bus_s2_reg <= bus_s1_reg;
   end

   // Card reset is unclocked and acts as soon as it is seen.
   assign resetting = !rst_n || !crst_s2_reg;
   assign cclk_rise = cclk_s2_reg && !cclk_s3_reg;

   always_ff @(posedge sys_clk) begin
      in_reset <= resetting;
   end

   // Clocked outputs float in reset and change only at card clock rises.
   always_ff @(posedge sys_clk) begin
      if (resetting) begin
         bus_oe_n_reg <= 1'b1;
         bus_o_reg <= '0;
         rx_data <= '0;
      end else if (cclk_rise) begin
         bus_oe_n_reg <= 1'b0;
         bus_o_reg <= tx_data;
         rx_data <= bus_s2_reg;
      end
   end

   // A pulse low on the released line asks for full clock; the line is
   // only pulled, never driven high, so it cannot fight the host.
   always_ff @(posedge sys_clk) begin
      if (resetting) begin
         pulse_reg <= '0;
         run_oe_n_reg <= 1'b1;
      end else if (pulse_reg != '0) begin
         pulse_reg <= pulse_reg - 1'b1;
         run_oe_n_reg <= (pulse_reg == 1) ? 1'b1 : 1'b0;
      end else if (need_clk && run_s2_reg == RUN_IDLE) begin
         pulse_reg <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
         run_oe_n_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      run_req_active <= !resetting && !run_oe_n_reg;
   end

   assign link.card_run_o = 1'b0;
   assign link.card_run_oe_n = run_oe_n_reg;
   assign link.card_bus_o = bus_o_reg;
   assign link.card_bus_oe_n = bus_oe_n_reg;

endmodule

// *** hdl/cardbus_clk_pkg.sv ***
package cardbus_clk_pkg;

   // Local clock and derived card clock timing.
   localparam int SYS_PERIOD_NS = 10;
   localparam int FULL_PERIOD_NS = 160;
   localparam int SLOW_PERIOD_NS = 640;
   localparam int FULL_HALF_CYC = FULL_PERIOD_NS / (2 * SYS_PERIOD_NS);
   localparam int SLOW_HALF_CYC = SLOW_PERIOD_NS / (2 * SYS_PERIOD_NS);

   // Clock-run handshake, counted in card clock rising edges.
   localparam int ANNOUNCE_CCLKS = 2;
   localparam int WAIT_CCLKS = 4;

   // Card reset held at least this many card clock rising edges.
   localparam int RESET_HOLD_CCLKS = 4;

   // Card side clock-run request pulse length.
   localparam int CARD_PULSE_NS = 320;
   localparam int CARD_PULSE_CYC = (CARD_PULSE_NS + SYS_PERIOD_NS - 1) /
                                   SYS_PERIOD_NS;

   // Width of the representative clocked socket signal group.
   localparam int BUS_W = 8;

   // Line level that the open-drain clock-run line rests at when released.
   localparam logic RUN_IDLE = 1'h1;

   typedef enum logic [1:0] {
      MODE_FULL,
      MODE_SLOW,
      MODE_STOP
   } clk_mode_t;

endpackage

// *** hdl/cardbus_host_clk.sv ***
`timescale 1ns/1ps
module cardbus_host_clk
   import cardbus_clk_pkg::*;
#(
   parameter int W = BUS_W,
   parameter int FULL_HALF = FULL_HALF_CYC,
   parameter int SLOW_HALF = SLOW_HALF_CYC,
   parameter int ANN_CCLKS = ANNOUNCE_CCLKS,
   parameter int WIN_CCLKS = WAIT_CCLKS,
   parameter int RST_CCLKS = RESET_HOLD_CCLKS
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic slow_req,
   input wire logic stop_req,
   input wire logic reset_req,
   output clk_mode_t mode,
   output logic crst_active,
   output logic [W-1:0] rx_data,
   output logic rx_valid,
   cardbus_link_if.host link
);
   typedef enum logic [2:0] {
      ST_RUN,
      ST_ANNOUNCE,
      ST_WAIT,
      ST_SLOW,
      ST_STOP
   } host_state_t;

   localparam int CW = $clog2(SLOW_HALF + 1);
   localparam int EW = 4;

   host_state_t state_reg;
   host_state_t state_next;
   logic [CW-1:0] div_reg;
   logic cclk_reg;
   logic [EW-1:0] ev_reg;
   logic [EW-1:0] ev_next;
   logic target_stop_reg;
   logic target_stop_next;
   logic [EW-1:0] rst_cnt_reg;
   logic crst_n_reg;
   logic run_o_reg;
   logic run_oe_n_reg;
   logic bus_oe_n_reg;
   logic run_s1_reg;
   logic run_s2_reg;
   logic own_s1_reg;
   logic own_s2_reg;
   logic [W-1:0] bus_s1_reg;
   logic [W-1:0] bus_s2_reg;
   logic [CW-1:0] half;
   logic tick;
   logic rise_evt;
   logic hold_low;
   logic card_wants;
   logic lower_wanted;

   function automatic logic [EW-1:0] bump(input logic [EW-1:0] v);
      bump = (v == {EW{1'b1}}) ? v : v + 1'b1;
   endfunction

   // Clock-run and the returned bus come from the card's domain.
   always_ff @(posedge sys_clk) begin
      run_s1_reg <= link.clkrun_n;
      run_s2_reg <= run_s1_reg;
      own_s1_reg <= run_oe_n_reg | run_o_reg;
      own_s2_reg <= own_s1_reg;
      bus_s1_reg <= link.bus;
      bus_s2_reg <= bus_s1_reg;
   end

   // The host's own drive is delayed beside the synchroniser, so a low
   // that the host made itself is never taken for a card request.
   assign card_wants = (run_s2_reg != RUN_IDLE) && (own_s2_reg == RUN_IDLE);
   assign lower_wanted = slow_req || stop_req;

   // Slow mode stretches the half period; everything else is full rate.
   assign half = (state_reg == ST_SLOW) ? CW'(SLOW_HALF) : CW'(FULL_HALF);
   // Stop only ever freezes a low clock, so no runt high phase appears.
   assign hold_low = (state_reg == ST_STOP) && !cclk_reg;
   assign tick = !hold_low && (div_reg >= half - 1'b1);
   assign rise_evt = tick && !cclk_reg;

   // Card clock divider: full rate is the host bus rate.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_reg <= '0;
         cclk_reg <= 1'b0;
      end else if (hold_low) begin
         // Parked at the end of the count, so a woken clock rises at once.
         div_reg <= (div_reg >= half - 1'b1) ? div_reg : div_reg + 1'b1;
         cclk_reg <= 1'b0;
      end else if (tick) begin
         div_reg <= '0;
         cclk_reg <= !cclk_reg;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // Clock-run sequencing.
   always_comb begin
      state_next = state_reg;
      ev_next = ev_reg;
      target_stop_next = target_stop_reg;
      unique case (state_reg)
         ST_RUN: begin
            ev_next = '0;
            if (crst_n_reg && lower_wanted && !card_wants) begin
               state_next = ST_ANNOUNCE;
               target_stop_next = stop_req;
            end
         end
         ST_ANNOUNCE: begin
            if (card_wants) begin
               state_next = ST_RUN;
            end else if (rise_evt) begin
               ev_next = bump(ev_reg);
               if (ev_reg == EW'(ANN_CCLKS - 1)) begin
                  state_next = ST_WAIT;
                  ev_next = '0;
               end
            end
         end
         ST_WAIT: begin
            if (card_wants || !lower_wanted || !crst_n_reg) begin
               state_next = ST_RUN;
            end else if (rise_evt) begin
               ev_next = bump(ev_reg);
               if (ev_reg == EW'(WIN_CCLKS - 1)) begin
                  state_next = target_stop_reg ? ST_STOP : ST_SLOW;
               end
            end
         end
         ST_SLOW, ST_STOP: begin
            if (card_wants || !crst_n_reg) begin
               state_next = ST_RUN;
            end else if (!lower_wanted ||
                         (state_reg == ST_SLOW) == stop_req) begin
               // A changed request goes through full rate and a new
               // announcement rather than switching modes silently.
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= ST_RUN;
         ev_reg <= '0;
         target_stop_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ev_reg <= ev_next;
         target_stop_reg <= target_stop_next;
      end
   end

   // The host holds clock-run low while the clock runs at full rate,
   // drives it high to announce a slowdown, then lets it float.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         run_o_reg <= 1'b0;
         run_oe_n_reg <= 1'b0;
      end else begin
         unique case (state_next)
            ST_RUN: begin
               run_o_reg <= 1'b0;
               run_oe_n_reg <= 1'b0;
            end
            ST_ANNOUNCE: begin
               run_o_reg <= RUN_IDLE;
               run_oe_n_reg <= 1'b0;
            end
            default: begin
               run_o_reg <= RUN_IDLE;
               run_oe_n_reg <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode <= MODE_FULL;
      end else begin
         unique case (state_next)
            ST_SLOW: mode <= MODE_SLOW;
            ST_STOP: mode <= MODE_STOP;
            default: mode <= MODE_FULL;
         endcase
      end
   end

   // Card reset: asserted at once, released only with a rising card
   // clock edge after a minimum number of edges has been seen.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || reset_req) begin
         crst_n_reg <= 1'b0;
         rst_cnt_reg <= '0;
      end else if (!crst_n_reg && rise_evt) begin
         rst_cnt_reg <= bump(rst_cnt_reg);
         if (rst_cnt_reg >= EW'(RST_CCLKS - 1)) begin
            crst_n_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      crst_active <= !crst_n_reg;
   end

   // While the card floats in reset the host parks the bus at low.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || reset_req) begin
         bus_oe_n_reg <= 1'b0;
      end else if (crst_n_reg) begin
         bus_oe_n_reg <= 1'b1;
      end
   end

   // Returned data is taken at the card clock rise; the card changes it
   // at the previous rise, so the synchroniser delay is well covered.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_data <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= rise_evt && crst_n_reg;
         if (rise_evt && crst_n_reg) begin
            rx_data <= bus_s2_reg;
         end
      end
   end

   assign link.cclk = cclk_reg;
   assign link.crst_n = crst_n_reg;
   assign link.host_run_o = run_o_reg;
   assign link.host_run_oe_n = run_oe_n_reg;
   assign link.host_bus_o = '0;
   assign link.host_bus_oe_n = bus_oe_n_reg;

endmodule

// *** hdl/cardbus_link_if.sv ***
`timescale 1ns/1ps
interface cardbus_link_if #(
   parameter int W = 8
);
   logic cclk;
   logic crst_n;
   logic host_run_o;
   logic host_run_oe_n;
   logic card_run_o;
   logic card_run_oe_n;
   logic clkrun_n;
   logic [W-1:0] host_bus_o;
   logic host_bus_oe_n;
   logic [W-1:0] card_bus_o;
   logic card_bus_oe_n;
   logic [W-1:0] bus;

   // Open-drain line with a pull-up: any enabled low driver wins.
   assign clkrun_n = (host_run_oe_n | host_run_o) &
                     (card_run_oe_n | card_run_o);
   // Undriven bus bits read low, standing in for a weak pull-down.
   assign bus = (host_bus_oe_n ? {W{1'b0}} : host_bus_o) |
                (card_bus_oe_n ? {W{1'b0}} : card_bus_o);

   modport host (
      output cclk,
      output crst_n,
      output host_run_o,
      output host_run_oe_n,
      output host_bus_o,
      output host_bus_oe_n,
      input clkrun_n,
      input bus
   );

   modport card (
      input cclk,
      input crst_n,
      input clkrun_n,
      input bus,
      output card_run_o,
      output card_run_oe_n,
      output card_bus_o,
      output card_bus_oe_n
   );
endinterface

// *** testbench/cardbus_socket_clock_reset_assertions.sv ***
`timescale 1ns/1ps
module cardbus_socket_clock_reset_assertions #(
   parameter int W = 8,
   parameter int FULL_HALF = 8,
   parameter int SLOW_HALF = 32
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cclk,
   input wire logic crst_n,
   input wire logic host_run_o,
   input wire logic host_run_oe_n,
   input wire logic card_run_oe_n,
   input wire logic clkrun_n,
   input wire logic host_bus_oe_n,
   input wire logic card_bus_oe_n,
   input wire logic [W-1:0] bus
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   int hi_cnt;
   int lo_cnt;

   // Run lengths of each clock level expose a slowed or parked clock.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hi_cnt <= 0;
      end else begin
         hi_cnt <= cclk ? hi_cnt + 1 : 0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lo_cnt <= 0;
      end else begin
         lo_cnt <= cclk ? 0 : lo_cnt + 1;
      end
   end

   a_full_rate_high: assert property ($rose(cclk) && !clkrun_n |->
      cclk [*8] ##1 !cclk) else $error("card clock high phase wrong");
   a_never_park_high: assert property (hi_cnt <= SLOW_HALF)
      else $error("card clock held high");
   a_slow_after_notice: assert property (crst_n &&
      (hi_cnt == FULL_HALF + 1 || lo_cnt == FULL_HALF + 1) |->
      $past(host_run_oe_n) || $past(host_run_o))
      else $error("slowdown not announced");
   a_request_restores: assert property ($fell(card_run_oe_n) |->
      ##[1:4] !host_run_oe_n && !host_run_o)
      else $error("card request not honoured");
   a_card_floats: assert property (!crst_n [*6] |->
      card_bus_oe_n && card_run_oe_n) else $error("card drives in reset");
   a_host_drives: assert property (!crst_n [*2] |-> !host_bus_oe_n)
      else $error("host not driving in reset");
   a_release_on_rise: assert property ($rose(crst_n) |-> $rose(cclk))
      else $error("reset released off clock edge");
   a_bus_steady_rise: assert property ($rose(cclk) && $past(crst_n) |->
      $stable(bus)) else $error("bus moved at clock rise");
   a_announce_first: assert property ($rose(host_run_oe_n) |->
      $past(host_run_o)) else $error("clock-run released unannounced");

   c_release: cover property ($rose(crst_n));
   c_mid_reset: cover property ($fell(crst_n));
   c_card_request: cover property ($fell(card_run_oe_n));
   c_clock_parked: cover property (lo_cnt == SLOW_HALF + 1);
endmodule

// *** testbench/cardbus_socket_clock_reset_tb.sv ***
`timescale 1ns/1ps
module cardbus_socket_clock_reset_tb;
   import cardbus_clk_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow_req = 1'b0;
   logic stop_req = 1'b0;
   logic reset_req = 1'b0;
   logic need_clk = 1'b0;
   logic [BUS_W-1:0] tx_data = 8'h00;
   clk_mode_t mode;
   logic crst_active;
   logic rx_valid;
   logic in_reset;
   logic [BUS_W-1:0] host_rx;
   logic [BUS_W-1:0] card_rx;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int k;
   logic [7:0] vals [4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};

   always #5 sys_clk = ~sys_clk;

   cardbus_link_if #(.W(BUS_W)) cardbus_link_if_i ();
   cardbus_host_clk cardbus_host_clk_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .slow_req(slow_req), .stop_req(stop_req), .reset_req(reset_req),
      .mode(mode), .crst_active(crst_active), .rx_data(host_rx),
      .rx_valid(rx_valid), .link(cardbus_link_if_i.host));
   cardbus_card_end cardbus_card_end_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .need_clk(need_clk), .tx_data(tx_data), .in_reset(in_reset),
      .run_req_active(), .rx_data(card_rx), .link(cardbus_link_if_i.card));
   cardbus_socket_clock_reset_assertions #(.W(BUS_W),
      .FULL_HALF(FULL_HALF_CYC), .SLOW_HALF(SLOW_HALF_CYC)) chk_i (
      .sys_clk(sys_clk),
      .rst_n(rst_n), .cclk(cardbus_link_if_i.cclk),
      .crst_n(cardbus_link_if_i.crst_n),
      .host_run_o(cardbus_link_if_i.host_run_o),
      .host_run_oe_n(cardbus_link_if_i.host_run_oe_n),
      .card_run_oe_n(cardbus_link_if_i.card_run_oe_n),
      .clkrun_n(cardbus_link_if_i.clkrun_n),
      .host_bus_oe_n(cardbus_link_if_i.host_bus_oe_n),
      .card_bus_oe_n(cardbus_link_if_i.card_bus_oe_n),
      .bus(cardbus_link_if_i.bus));

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Waits for a level on the card clock or card reset, counting cycles.
   task automatic wait_sig(input bit on_rst, input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while ((on_rst ? cardbus_link_if_i.crst_n : cardbus_link_if_i.cclk)
                 !== lvl && n < 400);
   endtask

   // Measures both phases of one whole card clock period.
   task automatic check_period(input int half);
      wait_sig(1'b0, 1'b1, k);
      wait_sig(1'b0, 1'b0, k);
      wait_sig(1'b0, 1'b1, k);
      check("low phase", 8'(k), 8'(half));
      wait_sig(1'b0, 1'b0, k);
      check("high phase", 8'(k), 8'(half));
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      wait_sig(1'b1, 1'b1, k);
      check("clock at release", cardbus_link_if_i.cclk, 8'h01);
      check_period(FULL_HALF_CYC);
      foreach (vals[i]) begin
         @(posedge sys_clk);
         tx_data <= vals[i];
         repeat (3) begin
            k = 0;
            do begin
               @(posedge sys_clk);
               #1;
               k++;
            end while (rx_valid !== 1'b1 && k < 100);
         end
         check("host data", host_rx, vals[i]);
         check("card data", card_rx, vals[i]);
      end
      @(posedge sys_clk);
      reset_req <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      check("reset line", cardbus_link_if_i.crst_n, 8'h00);
      check("host bus enable", cardbus_link_if_i.host_bus_oe_n, 8'h00);
      check("card bus enable", cardbus_link_if_i.card_bus_oe_n, 8'h01);
      check("card in reset", in_reset, 8'h01);
      check("reset shown", crst_active, 8'h01);
      check("bus in reset", cardbus_link_if_i.bus, 8'h00);
      @(posedge sys_clk);
      reset_req <= 1'b0;
      cnt_rises();
      check("clock at release", cardbus_link_if_i.cclk, 8'h01);
      // With no card interest the host announces, then slows the clock.
      @(posedge sys_clk);
      slow_req <= 1'b1;
      repeat (300) @(posedge sys_clk);
      #1;
      check("slow mode", 8'(mode), 8'(MODE_SLOW));
      check("clock run idle", cardbus_link_if_i.clkrun_n, 8'h01);
      check_period(SLOW_HALF_CYC);
      @(posedge sys_clk);
      need_clk <= 1'b1;
      repeat (40) @(posedge sys_clk);
      #1;
      check("mode under request", 8'(mode), 8'(MODE_FULL));
      check_period(FULL_HALF_CYC);
      @(posedge sys_clk);
      slow_req <= 1'b0;
      need_clk <= 1'b0;
      stop_req <= 1'b1;
      repeat (600) @(posedge sys_clk);
      #1;
      check("stop mode", 8'(mode), 8'(MODE_STOP));
      check("stopped clock", cardbus_link_if_i.cclk, 8'h00);
      check("clock run line", cardbus_link_if_i.clkrun_n, 8'h01);
      // A card request wakes a stopped clock.
      @(posedge sys_clk);
      need_clk <= 1'b1;
      repeat (40) @(posedge sys_clk);
      #1;
      check("mode after wake", 8'(mode), 8'(MODE_FULL));
      check_period(FULL_HALF_CYC);
      @(posedge sys_clk);
      stop_req <= 1'b0;
      need_clk <= 1'b0;
      stop_test();
   end

   // Release must land on the counted card clock rise, no sooner or later.
   task automatic cnt_rises();
      int rises;
      int n;
      logic prev;
      rises = 0;
      n = 0;
      #1;
      prev = cardbus_link_if_i.cclk;
      while (cardbus_link_if_i.crst_n !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         #1;
         if (cardbus_link_if_i.cclk === 1'b1 && prev === 1'b0) begin
            rises++;
         end
         prev = cardbus_link_if_i.cclk;
         n++;
      end
      check("rises to release", 8'(rises), 8'(RESET_HOLD_CCLKS));
   endtask
endmodule
